//--- alf_pkg.sv
package alf_pkg;
  localparam logic [7:0] ALF_ADDR_SINK_CONTROL = 8'h11;
  localparam logic [7:0] ALF_ADDR_BLINK_TIMERS = 8'h12;
  localparam logic [7:0] ALF_ADDR_FADE_TIMERS = 8'h13;
  localparam logic [7:0] ALF_RESET_SINK_CONTROL = 8'h00;
  localparam logic [7:0] ALF_RESET_BLINK_TIMERS = 8'h00;
  localparam logic [7:0] ALF_RESET_FADE_TIMERS = 8'h00;
  localparam logic [7:0] ALF_CTL_USED_MASK = 8'h3f;
  localparam int ALF_CTL_ROW3_MODE_BIT = 5;
  localparam int ALF_CTL_COL3_MODE_BIT = 4;
  localparam int ALF_CTL_LAW_BIT = 3;
  localparam int ALF_CTL_EN3_BIT = 2;
  localparam int ALF_CTL_EN2_BIT = 1;
  localparam int ALF_CTL_EN1_BIT = 0;
  localparam int ALF_BLK_ON_LSB = 6;
  localparam int ALF_BLK_OFF3_LSB = 4;
  localparam int ALF_BLK_OFF2_LSB = 2;
  localparam int ALF_BLK_OFF1_LSB = 0;
  localparam int ALF_FADE_OUT_LSB = 4;
  localparam int ALF_FADE_IN_LSB = 0;
  localparam logic [1:0] ALF_OFF_DISABLED = 2'h0;
  localparam logic [3:0] ALF_FADE_DISABLED = 4'h0;
  // all timer figures are in tenths of a second, the base tick
  localparam int ALF_TICK_MS = 100;
  localparam int ALF_CLK_MHZ = 100;
  localparam int ALF_TICK_CYCLES = ALF_TICK_MS * 1000 * ALF_CLK_MHZ;
  localparam int ALF_LEVEL_W = 6;
  localparam int ALF_LEVEL_STEPS = 64;
  localparam logic [5:0] ALF_LEVEL_MAX = 6'h3f;
  localparam logic [5:0] ALF_ON_T00 = 6'h02;
  localparam logic [5:0] ALF_ON_T01 = 6'h06;
  localparam logic [5:0] ALF_ON_T10 = 6'h08;
  localparam logic [5:0] ALF_ON_T11 = 6'h0c;
  localparam logic [5:0] ALF_OFF_T01 = 6'h06;
  localparam logic [5:0] ALF_OFF_T10 = 6'h08;
  localparam logic [5:0] ALF_OFF_T11 = 6'h0c;
  localparam logic [5:0] ALF_FADE_SHORT_STEP = 6'h03;
  localparam logic [3:0] ALF_FADE_KNEE_CODE = 4'ha;
  localparam logic [5:0] ALF_FADE_KNEE_T = 6'h1e;
  localparam logic [5:0] ALF_FADE_LONG_STEP = 6'h05;

  typedef enum logic [1:0] {ALF_IDLE, ALF_ON, ALF_OFF} alf_blink_t;

  function automatic logic [5:0] alf_on_ticks(input logic [1:0] code);
    case (code)
      2'h0: alf_on_ticks = ALF_ON_T00;
      2'h1: alf_on_ticks = ALF_ON_T01;
      2'h2: alf_on_ticks = ALF_ON_T10;
      default: alf_on_ticks = ALF_ON_T11;
    endcase
  endfunction

  function automatic logic [5:0] alf_off_ticks(input logic [1:0] code);
    case (code)
      2'h1: alf_off_ticks = ALF_OFF_T01;
      2'h2: alf_off_ticks = ALF_OFF_T10;
      default: alf_off_ticks = ALF_OFF_T11;
    endcase
  endfunction

  function automatic logic [5:0] alf_fade_ticks(input logic [3:0] code);
    logic [5:0] c;
    c = {2'h0, code};
    if (code <= ALF_FADE_KNEE_CODE)
      alf_fade_ticks = 6'(c * ALF_FADE_SHORT_STEP);
    else
      alf_fade_ticks = 6'(ALF_FADE_KNEE_T +
        (c - {2'h0, ALF_FADE_KNEE_CODE}) * ALF_FADE_LONG_STEP);
  endfunction
endpackage

//--- alf_aux_sink_control.sv
`timescale 1ns/1ps
module alf_sink
  import alf_pkg::*;
(
  input wire logic mclk,
  input wire logic rstN,
  input wire logic tick,
  input wire logic fineTick,
  input wire logic enable,
  input wire logic lawSquare,
  input wire logic [1:0] onCode,
  input wire logic [1:0] offCode,
  input wire logic [3:0] fadeInCode,
  input wire logic [3:0] fadeOutCode,
  output logic [5:0] sinkLevel
);
  alf_blink_t state_q, state_d;
  logic [5:0] phaseCnt_q, phaseCnt_d;
  logic [5:0] level_q, level_d;
  logic [5:0] fadeCnt_q, fadeCnt_d;
  logic [5:0] out_q, out_d;
  logic target;
  logic [5:0] dur;
  logic [11:0] square;

  always_comb begin
    state_d = state_q;
    phaseCnt_d = phaseCnt_q;
    case (state_q)
      ALF_IDLE: begin
        if (enable) begin
          state_d = ALF_ON; // R16
          phaseCnt_d = 6'h00;
        end
      end
      ALF_ON: begin
        if (!enable) begin
          state_d = ALF_IDLE; // R4
        end else if (offCode == ALF_OFF_DISABLED) begin
          phaseCnt_d = 6'h00; // R6 R7 R8
        end else if (tick) begin
          if (phaseCnt_q == 6'(alf_on_ticks(onCode) - 6'h01)) begin
            state_d = ALF_OFF; // R5 R10
            phaseCnt_d = 6'h00;
          end else begin
            phaseCnt_d = 6'(phaseCnt_q + 6'h01);
          end
        end
      end
      ALF_OFF: begin
        if (!enable) begin
          state_d = ALF_IDLE;
        end else if (offCode == ALF_OFF_DISABLED) begin
          // timer switched off mid-cycle: go back to steady on
          state_d = ALF_ON;
          phaseCnt_d = 6'h00;
        end else if (tick) begin
          if (phaseCnt_q == 6'(alf_off_ticks(offCode) - 6'h01)) begin
            state_d = ALF_ON; // R9 R10
            phaseCnt_d = 6'h00;
          end else begin
            phaseCnt_d = 6'(phaseCnt_q + 6'h01);
          end
        end
      end
      default: state_d = ALF_IDLE;
    endcase
  end

  always_comb begin
    target = (state_q == ALF_ON);
    dur = target ? alf_fade_ticks(fadeInCode) : alf_fade_ticks(fadeOutCode);
    level_d = level_q;
    fadeCnt_d = fadeCnt_q;
    // widen both factors first so the product keeps all twelve bits
    square = {6'h00, level_q} * {6'h00, level_q};
    if ((target && level_q != ALF_LEVEL_MAX) ||
        (!target && level_q != 6'h00)) begin
      if (dur == 6'h00) begin
        level_d = target ? ALF_LEVEL_MAX : 6'h00; // R11 R12
        fadeCnt_d = 6'h00;
      end else if (fineTick) begin
        // one level step per dur fine ticks: full ramp takes dur tenths
        if (fadeCnt_q >= 6'(dur - 6'h01)) begin
          fadeCnt_d = 6'h00;
          level_d = target ? 6'(level_q + 6'h01) : 6'(level_q - 6'h01); // R15 R16
        end else begin
          fadeCnt_d = 6'(fadeCnt_q + 6'h01);
        end
      end
    end else begin
      fadeCnt_d = 6'h00;
    end
    out_d = lawSquare ? square[11:6] : level_q; // R3
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ALF_IDLE;
      phaseCnt_q <= 6'h00;
      level_q <= 6'h00;
      fadeCnt_q <= 6'h00;
      out_q <= 6'h00;
    end else begin
      state_q <= state_d;
      phaseCnt_q <= phaseCnt_d;
      level_q <= level_d;
      fadeCnt_q <= fadeCnt_d;
      out_q <= out_d;
    end
  end

  assign sinkLevel = out_q;
endmodule

// Summary of operation
// R1 - row-three pin: mode 0 makes it sink three, 1 makes it gpio bit three
// R2 - column-three pin: mode 0 makes it sink two, 1 gpio bit seven
// R3 - fade law bit picks linear (0) or square (1) current ramp
// R4 - one enable bit per sink turns that sink on or off
// R5 - shared on-period code: 0.2, 0.6, 0.8 or 1.2 seconds
// R6 - sink three off code 00 disables blinking, sink stays on
// R7 - sink two off code 00 disables blinking, sink stays on
// R8 - sink one off code 00 disables blinking, sink stays on
// R9 - non-zero off codes give 0.6, 0.8 or 1.2 seconds off
// R10 - active off timer makes the sink alternate on and off periods
// R11 - fade-out code: 0 off, 0.3 s steps to 3.0, 0.5 s to 5.5
// R12 - fade-in code uses the same encoding as fade-out
// R13 - software sets fade times before setting any enable bit
// R14 - software keeps column-three mode 1 when that pin is not a sink
// R15 - fade up over fade-in time on enable, down over fade-out on disable
// R16 - blinking starts with on-period; fading applies at every transition
module alf_aux_sink_control
  import alf_pkg::*;
#(
  parameter int TICK_CYCLES = ALF_TICK_CYCLES
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic [5:0] sinkOneLevel,
  output logic [5:0] sinkTwoLevel,
  output logic [5:0] sinkThreeLevel,
  output logic rowThreePinGpio,
  output logic columnThreePinGpio
);
  localparam int FINE_CYCLES = TICK_CYCLES / ALF_LEVEL_STEPS;
  localparam int DIV_W = $clog2(FINE_CYCLES + 1);
  localparam logic [DIV_W-1:0] FINE_LAST = DIV_W'(FINE_CYCLES - 1);

  logic rstSync1_q, rstN_q;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] blk_q, blk_d;
  logic [7:0] fade_q, fade_d;
  logic [7:0] rd_q, rd_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [5:0] sub_q, sub_d;
  logic fineTick, tick;
  logic enOne, enTwo, enThree;

  // release of reset passes two flops, assertion is immediate
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_q <= 1'b0;
      rstN_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstN_q <= rstSync1_q;
    end
  end

  always_comb begin
    ctl_d = ctl_q;
    blk_d = blk_q;
    fade_d = fade_q;
    if (regWrEn) begin
      case (regAddr)
        ALF_ADDR_SINK_CONTROL: ctl_d = regWrData & ALF_CTL_USED_MASK;
        ALF_ADDR_BLINK_TIMERS: blk_d = regWrData;
        ALF_ADDR_FADE_TIMERS: fade_d = regWrData;
        default: ;
      endcase
    end
    case (regAddr)
      ALF_ADDR_SINK_CONTROL: rd_d = ctl_q;
      ALF_ADDR_BLINK_TIMERS: rd_d = blk_q;
      ALF_ADDR_FADE_TIMERS: rd_d = fade_q;
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      ctl_q <= ALF_RESET_SINK_CONTROL;
      blk_q <= ALF_RESET_BLINK_TIMERS;
      fade_q <= ALF_RESET_FADE_TIMERS;
      rd_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      blk_q <= blk_d;
      fade_q <= fade_d;
      rd_q <= rd_d;
    end
  end

  // fine tick divides the tenth-second tick into one step per level
  always_comb begin
    fineTick = (div_q == FINE_LAST);
    tick = fineTick && (sub_q == ALF_LEVEL_MAX);
    div_d = fineTick ? '0 : DIV_W'(div_q + 1'b1);
    sub_d = fineTick ? 6'(sub_q + 6'h01) : sub_q;
  end

  always_ff @(posedge mclk or negedge rstN_q) begin
    if (!rstN_q) begin
      div_q <= '0;
      sub_q <= 6'h00;
    end else begin
      div_q <= div_d;
      sub_q <= sub_d;
    end
  end

  // a shared pin in gpio mode never lights its sink
  assign enOne = ctl_q[ALF_CTL_EN1_BIT];
  assign enTwo = ctl_q[ALF_CTL_EN2_BIT] & ~ctl_q[ALF_CTL_COL3_MODE_BIT]; // R2
  assign enThree = ctl_q[ALF_CTL_EN3_BIT] & ~ctl_q[ALF_CTL_ROW3_MODE_BIT]; // R1
  assign rowThreePinGpio = ctl_q[ALF_CTL_ROW3_MODE_BIT]; // R1
  assign columnThreePinGpio = ctl_q[ALF_CTL_COL3_MODE_BIT]; // R2
  assign regRdData = rd_q;

  alf_sink uSinkOne (
    .mclk(mclk), .rstN(rstN_q), .tick(tick), .fineTick(fineTick),
    .enable(enOne), .lawSquare(ctl_q[ALF_CTL_LAW_BIT]),
    .onCode(blk_q[ALF_BLK_ON_LSB +: 2]),
    .offCode(blk_q[ALF_BLK_OFF1_LSB +: 2]), // R8
    .fadeInCode(fade_q[ALF_FADE_IN_LSB +: 4]),
    .fadeOutCode(fade_q[ALF_FADE_OUT_LSB +: 4]),
    .sinkLevel(sinkOneLevel)
  );

  alf_sink uSinkTwo (
    .mclk(mclk), .rstN(rstN_q), .tick(tick), .fineTick(fineTick),
    .enable(enTwo), .lawSquare(ctl_q[ALF_CTL_LAW_BIT]),
    .onCode(blk_q[ALF_BLK_ON_LSB +: 2]),
    .offCode(blk_q[ALF_BLK_OFF2_LSB +: 2]), // R7
    .fadeInCode(fade_q[ALF_FADE_IN_LSB +: 4]),
    .fadeOutCode(fade_q[ALF_FADE_OUT_LSB +: 4]),
    .sinkLevel(sinkTwoLevel)
  );

  alf_sink uSinkThree (
    .mclk(mclk), .rstN(rstN_q), .tick(tick), .fineTick(fineTick),
    .enable(enThree), .lawSquare(ctl_q[ALF_CTL_LAW_BIT]),
    .onCode(blk_q[ALF_BLK_ON_LSB +: 2]),
    .offCode(blk_q[ALF_BLK_OFF3_LSB +: 2]), // R6
    .fadeInCode(fade_q[ALF_FADE_IN_LSB +: 4]),
    .fadeOutCode(fade_q[ALF_FADE_OUT_LSB +: 4]),
    .sinkLevel(sinkThreeLevel)
  );
endmodule

//--- alf_aux_sink_control_sva.sv
`timescale 1ns/1ps
module alf_aux_sink_control_sva
  import alf_pkg::*;
#(
  parameter int TICK_CYCLES = ALF_TICK_CYCLES
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic [5:0] sinkOneLevel,
  input wire logic [5:0] sinkTwoLevel,
  input wire logic [5:0] sinkThreeLevel,
  input wire logic rowThreePinGpio,
  input wire logic columnThreePinGpio
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic wrCtl;
  logic mapped;
  assign wrCtl = regWrEn && regAddr == ALF_ADDR_SINK_CONTROL;
  assign mapped = regAddr inside {[8'h11:8'h13]};
  row_gpio_a: assert property (
    wrCtl |-> ##2 rowThreePinGpio == $past(regWrData[5], 2))
    else $error("row pin mode wrong");
  col_gpio_a: assert property (
    wrCtl |-> ##2 columnThreePinGpio == $past(regWrData[4], 2))
    else $error("column pin mode wrong");
  // a pin handed to gpio must never ramp its sink up
  row_hold_a: assert property (
    rowThreePinGpio && $past(rowThreePinGpio, 3)
    |-> sinkThreeLevel <= $past(sinkThreeLevel))
    else $error("sink three rose in gpio mode");
  col_hold_a: assert property (
    columnThreePinGpio && $past(columnThreePinGpio, 3)
    |-> sinkTwoLevel <= $past(sinkTwoLevel))
    else $error("sink two rose in gpio mode");
  unmapped_zero_a: assert property (!mapped |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  ctl_mask_a: assert property (
    regAddr == ALF_ADDR_SINK_CONTROL |=> regRdData[7:6] == 2'h0)
    else $error("unused control bits read set");
  read_back_a: assert property (
    regWrEn && mapped ##1 !regWrEn && $stable(regAddr) |=>
    regRdData == ($past(regWrData, 2) &
    ($past(wrCtl, 2) ? ALF_CTL_USED_MASK : 8'hff)))
    else $error("read back mismatch");
  read_stable_a: assert property (
    (!regWrEn && $stable(regAddr)) [*2] |=> $stable(regRdData))
    else $error("read data moved");
  cover property (sinkOneLevel == ALF_LEVEL_MAX);
  cover property ($fell(sinkOneLevel != 6'h00));
  cover property (wrCtl && regWrData[5]);
endmodule
bind alf_aux_sink_control alf_aux_sink_control_sva #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .mclk, .reset_n, .regAddr, .regWrEn, .regWrData, .regRdData,
  .sinkOneLevel, .sinkTwoLevel, .sinkThreeLevel, .rowThreePinGpio,
  .columnThreePinGpio);

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import alf_pkg::*;
  localparam int TC = 128;
  localparam logic [7:0] CT = ALF_ADDR_SINK_CONTROL;
  localparam logic [7:0] BT = ALF_ADDR_BLINK_TIMERS;
  localparam logic [7:0] FT = ALF_ADDR_FADE_TIMERS;
  logic mclk, reset_n, regWrEn, rowG, colG;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [5:0] s1, s2, s3;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int onT[4] = '{2, 6, 8, 12};
  int offT[4] = '{6, 6, 8, 12};
  alf_aux_sink_control #(.TICK_CYCLES(TC)) DUT (.mclk(mclk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdData(regRdData), .sinkOneLevel(s1), .sinkTwoLevel(s2),
    .sinkThreeLevel(s3), .rowThreePinGpio(rowG), .columnThreePinGpio(colG));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ceiling sits well above the longest fade and blink sequence
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkr(string nm, int e, int tol, int g);
    tests_run++;
    if (g < e - tol || g > e + tol) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrEn <= 1'b1;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    repeat (2) @(posedge mclk);
    #1 chk("regRdData", e, regRdData);
  endtask
  task automatic waitv(logic [5:0] v, output int n);
    n = 0;
    while (s1 !== v && n < 20000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task automatic lv3(logic [5:0] a, logic [5:0] b, logic [5:0] c);
    repeat (6) @(posedge mclk);
    #1 chk("sinkOne", {2'h0, a}, {2'h0, s1});
    chk("sinkTwo", {2'h0, b}, {2'h0, s2});
    chk("sinkThree", {2'h0, c}, {2'h0, s3});
  endtask
  task automatic t_regs;
    rd(CT, ALF_RESET_SINK_CONTROL);
    rd(BT, ALF_RESET_BLINK_TIMERS);
    rd(FT, ALF_RESET_FADE_TIMERS);
    wr(CT, 8'hf0);
    wr(BT, 8'ha5);
    wr(FT, 8'h5a);
    wr(8'h14, 8'hff);
    rd(CT, 8'h30);
    chk("rowGpio", 8'h01, {7'h0, rowG});
    chk("colGpio", 8'h01, {7'h0, colG});
    rd(BT, 8'ha5);
    rd(FT, 8'h5a);
    rd(8'h14, 8'h00);
    rd(8'h10, 8'h00);
    wr(FT, 8'h00);
    wr(BT, 8'h00);
  endtask
  task automatic t_steady;
    wr(CT, 8'h07);
    lv3(6'h3f, 6'h3f, 6'h3f);
    wr(CT, 8'h0f);
    lv3(6'h3e, 6'h3e, 6'h3e);
    wr(CT, 8'h37);
    lv3(6'h3f, 6'h00, 6'h00);
    wr(CT, 8'h00);
    lv3(6'h00, 6'h00, 6'h00);
  endtask
  task automatic t_blink;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(BT, {2'(i), 2'h0, 2'h0, (i == 0) ? 2'h1 : 2'(i)});
      wr(CT, 8'h05);
      // the sink is dark when enabled, so wait for it to light first
      waitv(6'h3f, n);
      chkr("enableDelay", 3, 0, n);
      waitv(6'h00, n);
      chkr("firstOn", onT[i] * TC - TC / 2, TC / 2 + 4, n);
      waitv(6'h3f, n);
      chkr("offTime", offT[i] * TC, 3, n);
      waitv(6'h00, n);
      chkr("onTime", onT[i] * TC, 3, n);
      chk("sinkThree", 8'h3f, {2'h0, s3});
      wr(CT, 8'h00);
    end
  endtask
  task automatic t_fade;
    int n;
    wr(BT, 8'h00);
    wr(FT, 8'ha1);
    wr(CT, 8'h01);
    waitv(6'h3f, n);
    chkr("fadeIn", 63 * 6, 10, n);
    wr(CT, 8'h00);
    waitv(6'h00, n);
    chkr("fadeOut", 63 * 60, 64, n);
    wr(FT, 8'h0b);
    wr(CT, 8'h01);
    waitv(6'h3f, n);
    chkr("fadeInKnee", 63 * 70, 74, n);
    wr(CT, 8'h00);
    lv3(6'h00, 6'h00, 6'h00);
  endtask
  initial begin
    reset_n = 1'b0;
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs;
    t_steady;
    t_blink;
    t_fade;
    test_done;
  end
endmodule
